// file: core/sbcsfl_core.sv
// sbcsfl_core: latched status flags of the system basis chip.
// assumes detector outputs and spi decode strobes are synchronous to
// sys_clk; the spi engine pulses flag_read with a mask of flags read.
`timescale 1ns/1ns
module sbcsfl_core #(
    parameter int SEL_STUCK_CYCLES = sbcsfl_pkg::SEL_STUCK_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic spi_select_n,
    input wire logic spi_parity_err,
    input wire logic flag_read,
    input wire sbcsfl_pkg::sbcsfl_flags_t flag_read_mask,
    input wire logic high_side_switch3_short,
    input wire logic high_side_switch2_short,
    input wire logic secondary_supply_under_threshold,
    input wire logic primary_supply_over_threshold,
    input wire logic high_side_switch0_over_temp,
    input wire logic flash_mode,
    input wire logic [15:0] wd_elapsed,
    input wire logic [15:0] wd_period,
    input wire logic wake_io13,
    input wire logic wake_io02,
    input wire logic spi_wake_cmd,
    input wire logic low_power_regulator_on_mode,
    input wire logic forced_wakeup_evt,
    input wire logic int_service_timeout,
    input wire logic wakeup_evt,
    input wire logic low_power_regulator_off_mode,
    input wire logic spi_reset_req,
    input wire logic debug_exit_hw,
    output logic [15:0] flags,
    output logic [15:0] read_data,
    output logic read_valid
);
    import sbcsfl_pkg::*;

    // ----------------------------------------------------------------
    // flag update
    // ----------------------------------------------------------------
    // set has priority, so an event landing on a read is never lost;
    // condition flags are set every cycle the condition stands, which
    // makes a read during the fault ineffective.
    function automatic logic flag_next(input logic cur, input logic set,
                                       input logic clr);
        flag_next = set | (cur & ~clr);
    endfunction

    sbcsfl_state_t st_q;
    sbcsfl_state_t st_d;
    logic [15:0] set_vec;
    logic [15:0] clr_vec;
    logic wd_over_now;
    logic sel_limit;

    // 23-bit products keep the percent compare exact for 16-bit counts
    assign wd_over_now = flash_mode &&
        ({7'h00, wd_elapsed} * 23'(100) >
         {7'h00, wd_period} * 23'(WD_HALF_PERCENT));
    assign sel_limit = st_q.sel_cnt == 16'(SEL_STUCK_CYCLES);

    always_comb begin
        set_vec = 16'h0000;
        set_vec[FLG_HS3_SHORT] = high_side_switch3_short;
        set_vec[FLG_HS2_SHORT] = high_side_switch2_short;
        set_vec[FLG_PARITY] = spi_parity_err;
        // a select that rises in the limit cycle was low for exactly
        // the limit, which is not yet longer than it
        set_vec[FLG_SEL_STUCK] = sel_limit & ~st_q.sel_hit &
                                 ~spi_select_n;
        set_vec[FLG_SEC_UV] = secondary_supply_under_threshold;
        set_vec[FLG_PRI_OV] = primary_supply_over_threshold;
        set_vec[FLG_HS0_THERMAL] = high_side_switch0_over_temp;
        set_vec[FLG_WD_HALF] = wd_over_now & ~st_q.wd_over;
        set_vec[FLG_WAKE_IO13] = wake_io13;
        set_vec[FLG_WAKE_IO02] = wake_io02;
        set_vec[FLG_WAKE_CMD] = spi_wake_cmd &
                                low_power_regulator_on_mode;
        set_vec[FLG_FORCED_WAKE] = forced_wakeup_evt;
        set_vec[FLG_INT_TIMEOUT] = int_service_timeout;
        set_vec[FLG_LP_OFF] = wakeup_evt &
                              low_power_regulator_off_mode;
        set_vec[FLG_SW_RESET] = spi_reset_req;
        set_vec[FLG_DEBUG_EXIT] = debug_exit_hw;
    end

    assign clr_vec = flag_read ? flag_read_mask : 16'h0000;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        for (int i = 0; i < NUM_FLAGS; i++) begin
            st_d.flags[i] = flag_next(st_q.flags[i], set_vec[i],
                                      clr_vec[i]);
        end
        // answer carries the value held before this read clears it
        st_d.rd_valid = flag_read;
        if (flag_read) begin
            st_d.rd_data = st_q.flags & flag_read_mask;
        end
        // select-low timer: saturates, one flag per low period
        if (spi_select_n) begin
            st_d.sel_cnt = CNT_RST;
            st_d.sel_hit = 1'b0;
        end else begin
            if (!sel_limit) begin
                st_d.sel_cnt = st_q.sel_cnt + 16'h0001;
            end
            if (sel_limit) begin
                st_d.sel_hit = 1'b1;
            end
        end
        st_d.wd_over = wd_over_now;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st_q <= '{flags: FLAGS_RST, rd_data: FLAGS_RST,
                      rd_valid: 1'b0, sel_cnt: CNT_RST,
                      sel_hit: 1'b0, wd_over: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign flags = st_q.flags;
    assign read_data = st_q.rd_data;
    assign read_valid = st_q.rd_valid;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    AST_HS3_HOLD: assert property (
        high_side_switch3_short |=> flags[FLG_HS3_SHORT])
        else $error("switch 3 short flag not held during fault");

    AST_HS2_CLEAR: assert property (
        flags[FLG_HS2_SHORT] && flag_read && flag_read_mask[FLG_HS2_SHORT]
        && !high_side_switch2_short |=> !flags[FLG_HS2_SHORT])
        else $error("switch 2 short flag not cleared by read");

    AST_PARITY_SET_WINS: assert property (
        spi_parity_err && flag_read && flag_read_mask[FLG_PARITY]
        |=> flags[FLG_PARITY] && read_valid)
        else $error("parity event lost against read");

    AST_SEL_STUCK: assert property (
        $rose(flags[FLG_SEL_STUCK]) |->
        $past(!spi_select_n) && $past(st_q.sel_cnt) ==
        16'(SEL_STUCK_CYCLES))
        else $error("select stuck flag set at wrong time");

    AST_UV_NOCLEAR: assert property (
        secondary_supply_under_threshold ##1 flag_read
        && secondary_supply_under_threshold |=> flags[FLG_SEC_UV])
        else $error("undervoltage flag cleared during fault");

    AST_OV_HOLD: assert property (
        primary_supply_over_threshold [*2] |=>
        flags[FLG_PRI_OV] && $past(flags[FLG_PRI_OV]))
        else $error("overvoltage flag dropped");

    AST_THERMAL: assert property (
        high_side_switch0_over_temp |=> flags[FLG_HS0_THERMAL])
        else $error("thermal flag not set");

    AST_WD_HALF: assert property (
        $rose(flags[FLG_WD_HALF]) |-> $past(flash_mode))
        else $error("watchdog half flag outside flash mode");

    AST_WAKE_SHARED: assert property (
        (wake_io13 |=> flags[FLG_WAKE_IO13]) and
        (wake_io02 |=> flags[FLG_WAKE_IO02]))
        else $error("wake source flag not set");

    AST_CMD_WAKE: assert property (
        $rose(flags[FLG_WAKE_CMD]) |->
        $past(spi_wake_cmd && low_power_regulator_on_mode))
        else $error("command wake flag without cause");

    AST_EVENT_FLAGS: assert property (
        (forced_wakeup_evt |=> flags[FLG_FORCED_WAKE]) and
        (int_service_timeout |=> flags[FLG_INT_TIMEOUT]) and
        (spi_reset_req |=> flags[FLG_SW_RESET]) and
        (debug_exit_hw |=> flags[FLG_DEBUG_EXIT]))
        else $error("event flag not set");

    AST_LP_OFF: assert property (
        $rose(flags[FLG_LP_OFF]) |->
        $past(wakeup_evt && low_power_regulator_off_mode))
        else $error("low power history flag without cause");

    AST_READ_DATA: assert property (
        flag_read |=> read_valid &&
        read_data == ($past(flags) & $past(flag_read_mask)) ##1
        !read_valid || $past(flag_read))
        else $error("read answer not the pre-clear value");

    AST_HS3_CLEAR: assert property (
        flags[FLG_HS3_SHORT] && flag_read && flag_read_mask[FLG_HS3_SHORT]
        && !high_side_switch3_short |=> !flags[FLG_HS3_SHORT])
        else $error("switch 3 short flag not cleared by read");

    AST_HS2_HOLD: assert property (
        high_side_switch2_short |=> flags[FLG_HS2_SHORT])
        else $error("switch 2 short flag not held during fault");

    AST_PARITY_CLEAR: assert property (
        flags[FLG_PARITY] && flag_read && flag_read_mask[FLG_PARITY]
        && !spi_parity_err |=> !flags[FLG_PARITY])
        else $error("parity flag not cleared by read");

    AST_SEL_CLEAR: assert property (
        flags[FLG_SEL_STUCK] && flag_read && flag_read_mask[FLG_SEL_STUCK]
        && !set_vec[FLG_SEL_STUCK] |=> !flags[FLG_SEL_STUCK])
        else $error("select stuck flag not cleared by read");

    AST_SEL_ONCE: assert property (
        st_q.sel_hit |=> !$rose(flags[FLG_SEL_STUCK]))
        else $error("select stuck flag set twice in one low period");

    AST_UV_CLEAR: assert property (
        flags[FLG_SEC_UV] && flag_read && flag_read_mask[FLG_SEC_UV]
        && !secondary_supply_under_threshold |=> !flags[FLG_SEC_UV])
        else $error("undervoltage flag not cleared after recovery");

    AST_OV_CLEAR: assert property (
        flags[FLG_PRI_OV] && flag_read && flag_read_mask[FLG_PRI_OV]
        && !primary_supply_over_threshold |=> !flags[FLG_PRI_OV])
        else $error("overvoltage flag not cleared after recovery");

    AST_THERMAL_CLEAR: assert property (
        flags[FLG_HS0_THERMAL] && flag_read
        && flag_read_mask[FLG_HS0_THERMAL]
        && !high_side_switch0_over_temp |=> !flags[FLG_HS0_THERMAL])
        else $error("thermal flag not cleared after cooling");

    AST_WD_SET: assert property (
        wd_over_now && !st_q.wd_over |=> flags[FLG_WD_HALF])
        else $error("watchdog half flag not set");

    AST_WD_CLEAR: assert property (
        flags[FLG_WD_HALF] && flag_read && flag_read_mask[FLG_WD_HALF]
        && !set_vec[FLG_WD_HALF] |=> !flags[FLG_WD_HALF])
        else $error("watchdog half flag not cleared by read");

    AST_CMD_SET: assert property (
        spi_wake_cmd && low_power_regulator_on_mode
        |=> flags[FLG_WAKE_CMD])
        else $error("command wake flag not set");

    AST_LP_OFF_SET: assert property (
        wakeup_evt && low_power_regulator_off_mode
        |=> flags[FLG_LP_OFF])
        else $error("low power history flag not set");

    AST_READ_CLEARS: assert property (
        flag_read |=>
        (flags & $past(flag_read_mask) & ~$past(set_vec)) == 16'h0000)
        else $error("read left a quiet flag set");

    AST_NO_LOST_FLAG: assert property (
        ($past(flags) & ~flags & ~($past(flag_read_mask) &
        {16{$past(flag_read)}})) == 16'h0000)
        else $error("flag dropped without a read");

    AST_NO_FALSE_SET: assert property (
        (flags & ~$past(flags) & ~$past(set_vec)) == 16'h0000)
        else $error("flag rose without its event");

    AST_VALID_PULSE: assert property (
        read_valid |-> $past(flag_read))
        else $error("read answer without a read");

    AST_READ_IDLE: assert property (
        !flag_read |=> !read_valid && $stable(read_data))
        else $error("read answer changed without a read");

    COV_STUCK: cover property ($rose(flags[FLG_SEL_STUCK]));
    COV_FAULT_READ: cover property (
        high_side_switch3_short ##1 flag_read ##1
        !high_side_switch3_short ##1 flag_read);
    COV_WD_HALF: cover property ($rose(flags[FLG_WD_HALF]));
    COV_COLLIDE: cover property (spi_parity_err && flag_read);
endmodule // sbcsfl_core

// file: core/sbcsfl_pkg.sv
// sbcsfl_pkg: constants and state type of the status flag latch bank.
// assumes a single 20 MHz system clock.
package sbcsfl_pkg;
    // ----------------------------------------------------------------
    // flag positions
    // ----------------------------------------------------------------
    localparam int NUM_FLAGS = 16;
    localparam int FLG_HS3_SHORT = 0;
    localparam int FLG_HS2_SHORT = 1;
    localparam int FLG_PARITY = 2;
    localparam int FLG_SEL_STUCK = 3;
    localparam int FLG_SEC_UV = 4;
    localparam int FLG_PRI_OV = 5;
    localparam int FLG_HS0_THERMAL = 6;
    localparam int FLG_WD_HALF = 7;
    localparam int FLG_WAKE_IO13 = 8;
    localparam int FLG_WAKE_IO02 = 9;
    localparam int FLG_WAKE_CMD = 10;
    localparam int FLG_FORCED_WAKE = 11;
    localparam int FLG_INT_TIMEOUT = 12;
    localparam int FLG_LP_OFF = 13;
    localparam int FLG_SW_RESET = 14;
    localparam int FLG_DEBUG_EXIT = 15;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] FLAGS_RST = 16'h0000;
    localparam logic [15:0] CNT_RST = 16'h0000;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_FREQ_KHZ = 20000;
    localparam int SEL_STUCK_TIME_US = 2000;
    // least time, rounded up to whole cycles
    localparam int SEL_STUCK_CYCLES =
        (SEL_STUCK_TIME_US * CLK_FREQ_KHZ + 999) / 1000;
    localparam int WD_HALF_PERCENT = 50;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef logic [15:0] sbcsfl_flags_t;

    typedef struct packed {
        logic [15:0] flags;
        logic [15:0] rd_data;
        logic rd_valid;
        logic [15:0] sel_cnt;
        logic sel_hit;
        logic wd_over;
    } sbcsfl_state_t;
endpackage

// file: bench/sbcsfl_mcu_model.sv
// sbcsfl_mcu_model: microcontroller side that reads flags over spi.
// assumes req is a one-cycle pulse driven just after the rising edge.
`timescale 1ns/1ns
module sbcsfl_mcu_model (
    input wire logic req,
    input wire logic [15:0] req_mask,
    output logic flag_read,
    output logic [15:0] flag_read_mask
);
    // idle mask is inverted so a stale mask never looks like a request
    always_comb begin
        flag_read = req;
        flag_read_mask = req ? req_mask : ~req_mask;
    end
endmodule // sbcsfl_mcu_model

// file: bench/testbench.sv
// testbench: self-checking bench of the status flag latch bank.
// assumes sbcsfl_core and sbcsfl_mcu_model; short select-stuck count.
`timescale 1ns/1ns
module testbench;
    import sbcsfl_pkg::*;
    localparam int N = 16;
    logic sys_clk, reset, sel_n, flash, lp_on, lp_off, req, frd, rv;
    logic [15:0] det, mask, rmask, wd_el, wd_per, flg, rdat;
    int errors, n_checks;
    sbcsfl_mcu_model mcu (.req(req), .req_mask(mask), .flag_read(frd),
        .flag_read_mask(rmask));
    sbcsfl_core #(.SEL_STUCK_CYCLES(N)) uut (.sys_clk(sys_clk),
        .reset(reset), .spi_select_n(sel_n), .spi_parity_err(det[2]),
        .flag_read(frd), .flag_read_mask(rmask),
        .high_side_switch3_short(det[0]), .high_side_switch2_short(det[1]),
        .secondary_supply_under_threshold(det[4]),
        .primary_supply_over_threshold(det[5]),
        .high_side_switch0_over_temp(det[6]), .flash_mode(flash),
        .wd_elapsed(wd_el), .wd_period(wd_per), .wake_io13(det[8]),
        .wake_io02(det[9]), .spi_wake_cmd(det[10]),
        .low_power_regulator_on_mode(lp_on), .forced_wakeup_evt(det[11]),
        .int_service_timeout(det[12]), .wakeup_evt(det[13]),
        .low_power_regulator_off_mode(lp_off), .spi_reset_req(det[14]),
        .debug_exit_hw(det[15]), .flags(flg), .read_data(rdat),
        .read_valid(rv));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(posedge sys_clk);
        #5;
    endtask
    task automatic rd(logic [15:0] m, logic [15:0] exp);
        req = 1'b1;
        mask = m;
        step(1);
        req = 1'b0;
        check("read_data", rdat, exp);
        check("read_valid", {15'h0000, rv}, 16'h0001);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_events();
        int ev[9] = '{2, 8, 9, 10, 11, 12, 13, 14, 15};
        foreach (ev[i]) begin
            det[ev[i]] = 1'b1;
            step(1);
            det[ev[i]] = 1'b0;
            check("set", flg, 16'h0001 << ev[i]);
            rd(16'h0001 << ev[i], 16'h0001 << ev[i]);
            check("clear", flg, 16'h0000);
        end
        lp_on = 1'b0;
        lp_off = 1'b0;
        det[10] = 1'b1;
        det[13] = 1'b1;
        step(1);
        det[10] = 1'b0;
        det[13] = 1'b0;
        step(1);
        check("wake mode off", flg, 16'h0000);
    endtask
    task automatic t_cond();
        int cd[5] = '{0, 1, 4, 5, 6};
        foreach (cd[i]) begin
            det[cd[i]] = 1'b1;
            step(2);
            rd(16'h0001 << cd[i], 16'h0001 << cd[i]);
            check("held", flg, 16'h0001 << cd[i]);
            det[cd[i]] = 1'b0;
            step(1);
            check("kept", flg, 16'h0001 << cd[i]);
            rd(16'h0001 << cd[i], 16'h0001 << cd[i]);
            check("gone", flg, 16'h0000);
        end
    endtask
    task automatic t_stuck();
        int k;
        k = 0;
        // low for exactly the limit is not yet stuck
        sel_n = 1'b0;
        step(N);
        sel_n = 1'b1;
        step(1);
        check("stuck cut", flg, 16'h0000);
        sel_n = 1'b0;
        while (flg[3] !== 1'b1 && k < 40) begin
            step(1);
            k++;
        end
        sel_n = 1'b1;
        check("stuck time", 16'(k >= N + 1 && k <= N + 3), 16'h0001);
        if (k >= 40) results();
        rd(16'h0008, 16'h0008);
        check("stuck clear", flg, 16'h0000);
    endtask
    task automatic t_wd();
        flash = 1'b1;
        wd_per = 16'h0064;
        wd_el = 16'h0032;
        step(2);
        check("wd at half", flg, 16'h0000);
        wd_el = 16'h0033;
        step(2);
        check("wd past half", flg, 16'h0080);
        rd(16'h0080, 16'h0080);
        check("wd clear", flg, 16'h0000);
        flash = 1'b0;
        step(2);
        check("wd no flash", flg, 16'h0000);
    endtask
    // a set in the cycle of its own read must survive
    task automatic t_race();
        det = 16'h0104;
        step(1);
        det[8] = 1'b0;
        rd(16'h0004, 16'h0004);
        check("set wins", flg, 16'h0104);
        det = 16'h0000;
        step(1);
        rd(16'hFFFF, 16'h0104);
        check("all clear", flg, 16'h0000);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        errors = 0;
        n_checks = 0;
        reset = 1'b1;
        {sel_n, flash, lp_on, lp_off, req} = 5'h16;
        {det, mask, wd_el, wd_per} = 64'h0000000000000000;
        repeat (4) @(posedge sys_clk);
        #5 reset = 1'b0;
        step(1);
        check("reset flags", flg, 16'h0000);
        check("reset valid", {15'h0000, rv}, 16'h0000);
        t_events();
        t_cond();
        t_stuck();
        t_wd();
        t_race();
        results();
    end
endmodule // testbench
